// ---- tiw_pkg.sv ----
// package for the target image window decode block
// assumes a 32-bit apb register bus and four target images
package tiw_pkg;

  // ==========================================================================
  // register map
  localparam logic [11:0] TRANSLATION_ADDRESS_OFS0       = 12'h104;
  localparam logic [11:0] TRANSLATION_ADDRESS_OFS1       = 12'h114;
  localparam logic [11:0] TRANSLATION_ADDRESS_OFS2       = 12'h124;
  localparam logic [11:0] TRANSLATION_ADDRESS_OFS3       = 12'h134;
  localparam logic [11:0] CTL_OFS0         = 12'h100;
  localparam logic [11:0] CTL_OFS1         = 12'h110;
  localparam logic [11:0] CTL_OFS2         = 12'h120;
  localparam logic [11:0] CTL_OFS3         = 12'h130;
  localparam logic [11:0] GLOBAL_OFS       = 12'h140;
  localparam logic [11:0] STATUS_OFS       = 12'h14C;
  localparam int          NUM_IMAGES       = 4;

  // ==========================================================================
  // translation register fields
  localparam int          TRANSLATION_ADDRESS_LSB        = 16;
  localparam int          MSEL_LSB         = 1;
  localparam logic [31:0] TRANSLATION_ADDRESS_MASK       = 32'hFFFF_00FE;

  // ==========================================================================
  // image control fields
  localparam int          END_LSB          = 0;
  localparam int          MRA_BIT          = 2;
  localparam int          AMT_LSB          = 3;
  localparam int          BS_LSB           = 6;
  localparam int          MODE_BIT         = 10;
  localparam int          MEMIO_BIT        = 11;
  localparam int          DEST_BIT         = 12;
  localparam int          TAEN_BIT         = 13;
  localparam int          MDEN_BIT         = 14;
  localparam int          KEEP_BIT         = 15;
  localparam logic [31:0] CTL_MASK         = 32'h0000_FFFF;
  localparam logic [31:0] CTL_RESET        = 32'h0000_0002;

  // ==========================================================================
  // global control fields
  localparam int          ARB_EN_BIT       = 0;
  localparam int          PIN5_BIT         = 1;
  localparam logic [31:0] GLOBAL_MASK      = 32'h0000_000F;

  // ==========================================================================
  // encodings
  localparam logic [1:0]  ENDIAN_BIG       = 2'h2;
  localparam logic [7:0]  BYTES_IO         = 8'h04;
  localparam logic [7:0]  BYTES_MIN        = 8'h08;

  typedef enum logic [1:0] {
    CMD_MEM_READ   = 2'b00,
    CMD_MEM_RDMULT = 2'b01,
    CMD_IO         = 2'b10,
    CMD_OTHER      = 2'b11
  } src_cmd_e;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_RESULT = 2'b01
  } dec_state_e;

endpackage

// ---- tiw_cfg_if.sv ----
// interface carrying one image's settings from register file to decoder
// assumes a single clock domain
`timescale 1ns/1ps
`default_nettype none
interface tiw_cfg_if;
  logic [31:0] ctl;
  logic [31:0] translation_address;
  logic [3:0]  global_ctl;
  modport regs (output ctl, output translation_address, output global_ctl);
  modport dec  (input ctl, input translation_address, input global_ctl);
endinterface
`default_nettype wire

// ---- tiw_image_dec.sv ----
// combinational decode of one target image request
// assumes settings stay constant during a transaction except translation
`timescale 1ns/1ps
`default_nettype none
module tiw_image_dec
  import tiw_pkg::*;
(
  tiw_cfg_if.dec              cfg,
  input  wire logic [31:0]    i_addr,
  input  wire logic [1:0]     i_cmd,
  input  wire logic [2:0]     i_master,
  input  wire logic           i_burst,
  output logic                o_claim,
  output logic [31:0]         o_dest_addr,
  output logic [1:0]          o_dest_cmd,
  output logic [7:0]          o_fetch_bytes,
  output logic [1:0]          o_endian,
  output logic                o_disconnect,
  output logic                o_keep
);

  // ==========================================================================
  // helpers
  function automatic logic [7:0] amt_bytes(input logic [2:0] code);
    amt_bytes = (code > 3'h4) ? BYTES_MIN : (BYTES_MIN << code);
  endfunction

  function automatic logic [31:0] bs_mask(input logic [3:0] bs);
    bs_mask = 32'hFFFF_0000 << bs;
  endfunction

  // ==========================================================================
  // fields
  wire logic [1:0]  endian  = cfg.ctl[END_LSB +: 2];
  wire logic        read_alias_enable     = cfg.ctl[MRA_BIT];
  wire logic [2:0]  amt     = cfg.ctl[AMT_LSB +: 3];
  wire logic [3:0]  bs      = cfg.ctl[BS_LSB +: 4];
  wire logic        io_mode = cfg.ctl[MODE_BIT];
  wire logic        mem_io  = cfg.ctl[MEMIO_BIT];
  wire logic        to_pci  = cfg.ctl[DEST_BIT];
  wire logic        translation_enable   = cfg.ctl[TAEN_BIT];
  wire logic        master_decode_enable   = cfg.ctl[MDEN_BIT];
  wire logic [6:0]  msel    = cfg.translation_address[MSEL_LSB +: 7];
  wire logic [31:0] umask   = bs_mask(bs);
  wire logic [31:0] tbase   = {cfg.translation_address[31:TRANSLATION_ADDRESS_LSB], 16'h0000};

  // ==========================================================================
  // master qualification
  wire logic [6:0] pin_ok  = {cfg.global_ctl[3:1], 4'hF};
  wire logic       sel_bit = (i_master != 3'h0) && msel[i_master - 3'h1] && pin_ok[i_master - 3'h1];
  wire logic       md_act  = cfg.global_ctl[ARB_EN_BIT] && master_decode_enable;
  assign o_claim = !md_act || sel_bit;

  // ==========================================================================
  // address translation
  assign o_dest_addr = translation_enable ? ((tbase & umask) | (i_addr & ~umask)) : i_addr;

  // ==========================================================================
  // command, size and endian
  wire logic io_cyc  = to_pci && io_mode && !mem_io;
  wire logic is_read = (i_cmd == CMD_MEM_READ);
  wire logic is_rm   = (i_cmd == CMD_MEM_RDMULT) || (is_read && read_alias_enable);
  wire logic io_src  = (i_cmd == CMD_IO);

  assign o_dest_cmd = io_cyc ? CMD_IO :
                      (io_src && mem_io) ? CMD_MEM_READ :
                      (is_rm ? CMD_MEM_RDMULT : i_cmd);
  assign o_fetch_bytes = io_cyc ? BYTES_IO :
                         (to_pci && io_mode) ? BYTES_IO :
                         (io_src && mem_io) ? BYTES_IO :
                         is_rm ? amt_bytes(amt) : BYTES_MIN;
  assign o_disconnect = io_cyc && i_burst;
  assign o_keep = cfg.ctl[KEEP_BIT] && !(to_pci && io_mode);
  assign o_endian = to_pci ? ENDIAN_BIG : endian;

endmodule
`default_nettype wire

// ---- tiw_top.sv ----
// target image window decode: apb registers plus per-request decode
// assumes synchronous inputs on i_core_clk and a request held for one cycle
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - endian field resets to big-endian and applies only toward the processor bus
// - read alias on turns plain memory read into read multiple using prefetch amount
// - read alias off prefetches exactly eight bytes on plain memory read
// - prefetch code selects 8, 16, 32, 64 or 128 bytes
// - block size code sets 64 KB doubling to 2 GB compare range
// - command mode matters only when destination is alternate pci bus
// - memory mode gives memory commands, bursts, prefetch keep and amount
// - io mode gives io commands limited to four bytes
// - burst to io mode image disconnects after each data beat
// - mode and io-as-memory bit pick memory eight, io, or memory four
// - translation enable replaces upper address bits within block size
// - translation address may change mid-transfer; other settings must stay fixed
// - seven master select bits choose which masters the image claims
// - master decode needs arbiter enable and image master decode enable
// - bits one to four map primary pairs; five to seven need shared-pin assignment
// - io-as-memory turns io commands into memory reads of four bytes
module tiw_top
  import tiw_pkg::*;
(
  input  wire logic              i_core_clk,
  input  wire logic              i_sys_rst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              i_req_valid,
  input  wire logic [1:0]        i_req_image,
  input  wire logic [31:0]       i_req_addr,
  input  wire logic [1:0]        i_req_cmd,
  input  wire logic [2:0]        i_req_master,
  input  wire logic              i_req_burst,
  output logic                   o_res_valid,
  output logic                   o_res_claim,
  output logic [31:0]            o_res_addr,
  output logic [1:0]             o_res_cmd,
  output logic [7:0]             o_res_bytes,
  output logic [1:0]             o_res_endian,
  output logic                   o_res_disconnect,
  output logic                   o_res_keep
);

  import tiw_pkg::*;

  // ==========================================================================
  // registers
  logic [31:0] ctl   [NUM_IMAGES];
  logic [31:0] translation_address [NUM_IMAGES];
  logic [3:0]  global_ctl;
  logic [15:0] res_count;
  dec_state_e  state;

  // ==========================================================================
  // apb decode
  function automatic logic [2:0] reg_slot(input logic [11:0] a);
    case (a)
      CTL_OFS0, TRANSLATION_ADDRESS_OFS0: reg_slot = 3'h0;
      CTL_OFS1, TRANSLATION_ADDRESS_OFS1: reg_slot = 3'h1;
      CTL_OFS2, TRANSLATION_ADDRESS_OFS2: reg_slot = 3'h2;
      CTL_OFS3, TRANSLATION_ADDRESS_OFS3: reg_slot = 3'h3;
      default:              reg_slot = 3'h4;
    endcase
  endfunction

  wire logic       access   = psel && penable;
  wire logic [2:0] slot     = reg_slot(paddr);
  wire logic       is_img   = (slot != 3'h4);
  wire logic       is_translation_address = is_img && paddr[2];
  wire logic       is_glob  = (paddr == GLOBAL_OFS);
  wire logic       is_stat  = (paddr == STATUS_OFS);
  wire logic       mapped   = is_img || is_glob || is_stat;
  wire logic [1:0] idx      = slot[1:0];

  wire logic [31:0] rd_img  = is_translation_address ? translation_address[idx] : ctl[idx];
  wire logic [31:0] rd_val  = is_img  ? rd_img :
                              is_glob ? {28'h0, global_ctl} :
                              is_stat ? {15'h0, state == ST_RESULT, res_count} : 32'h0;

  // ==========================================================================
  // register writes
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      for (int k = 0; k < NUM_IMAGES; k++) begin
        ctl[k]   <= CTL_RESET;
        translation_address[k] <= 32'h0;
      end
      global_ctl <= 4'h0;
    end else if (access && pwrite && pready) begin
      if (is_translation_address) translation_address[idx] <= pwdata & TRANSLATION_ADDRESS_MASK;
      else if (is_img) ctl[idx] <= pwdata & CTL_MASK;
      else if (is_glob) global_ctl <= pwdata[3:0] & GLOBAL_MASK[3:0];
    end
  end

  // ==========================================================================
  // apb answer: one wait state, ready pulses in the second access cycle
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready  <= access && !pready;
      prdata  <= (access && !pready && !pwrite) ? rd_val : 32'h0;
      pslverr <= access && !pready && !mapped;
    end
  end

  // ==========================================================================
  // decode of the selected image
  tiw_cfg_if cfg_bus ();
  assign cfg_bus.ctl        = ctl[i_req_image];
  assign cfg_bus.translation_address      = translation_address[i_req_image];
  assign cfg_bus.global_ctl = global_ctl;

  logic        d_claim;
  logic [31:0] d_addr;
  logic [1:0]  d_cmd;
  logic [7:0]  d_bytes;
  logic [1:0]  d_endian;
  logic        d_disc;
  logic        d_keep;

  tiw_image_dec u_dec (
    .cfg           (cfg_bus),
    .i_addr        (i_req_addr),
    .i_cmd         (i_req_cmd),
    .i_master      (i_req_master),
    .i_burst       (i_req_burst),
    .o_claim       (d_claim),
    .o_dest_addr   (d_addr),
    .o_dest_cmd    (d_cmd),
    .o_fetch_bytes (d_bytes),
    .o_endian      (d_endian),
    .o_disconnect  (d_disc),
    .o_keep        (d_keep)
  );

  // ==========================================================================
  // result register
  wire dec_state_e next_state = i_req_valid ? ST_RESULT : ST_IDLE;

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      state            <= ST_IDLE;
      res_count        <= 16'h0;
      o_res_valid      <= 1'b0;
      o_res_claim      <= 1'b0;
      o_res_addr       <= 32'h0;
      o_res_cmd        <= 2'h0;
      o_res_bytes      <= 8'h0;
      o_res_endian     <= ENDIAN_BIG;
      o_res_disconnect <= 1'b0;
      o_res_keep       <= 1'b0;
    end else begin
      state       <= next_state;
      o_res_valid <= i_req_valid;
      if (i_req_valid) begin
        res_count        <= res_count + 16'h1;
        o_res_claim      <= d_claim;
        o_res_addr       <= d_addr;
        o_res_cmd        <= d_cmd;
        o_res_bytes      <= d_bytes;
        o_res_endian     <= d_endian;
        o_res_disconnect <= d_disc;
        o_res_keep       <= d_keep;
      end
    end
  end

endmodule
`default_nettype wire

// ---- tiw_top_properties.sv ----
// checker bound onto the target image window decode top
// assumes one clock i_core_clk and a synchronous active high reset
`timescale 1ns/1ps
`default_nettype none
module tiw_checker
  import tiw_pkg::*;
(
  input wire logic        i_core_clk,
  input wire logic        i_sys_rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        i_req_valid,
  input wire logic [31:0] i_req_addr,
  input wire logic        i_req_burst,
  input wire logic        o_res_valid,
  input wire logic [31:0] o_res_addr,
  input wire logic [7:0]  o_res_bytes,
  input wire logic [1:0]  o_res_endian,
  input wire logic        o_res_disconnect
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_sys_rst);
  // ==========================================================================
  // port relations
  a_res_one_late: assert property (o_res_valid == $past(i_req_valid))
    else $error("result strobe misplaced");
  a_disc_burst: assert property (o_res_valid && o_res_disconnect |-> $past(i_req_burst))
    else $error("disconnect without burst");
  a_disc_four: assert property (o_res_valid && o_res_disconnect |-> o_res_bytes == BYTES_IO)
    else $error("io transfer above four bytes");
  a_bytes_legal: assert property (o_res_valid |-> o_res_bytes inside
    {8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80}) else $error("fetch size illegal");
  a_low_pass: assert property (o_res_valid |-> o_res_addr[15:0] == $past(i_req_addr[15:0]))
    else $error("low address bits altered");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_ready_time: assert property ($rose(penable) && psel |=> pready)
    else $error("register answer late");
  a_endian_rst: assert property ($fell(i_sys_rst) |-> o_res_endian == ENDIAN_BIG)
    else $error("endian not big after reset");
  cover property (o_res_valid && o_res_disconnect);
  cover property (o_res_valid && o_res_bytes == 8'h80);
  cover property (pready && psel);
endmodule
bind tiw_top tiw_checker i_tiw_checker (
  .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .psel(psel), .penable(penable),
  .pready(pready), .i_req_valid(i_req_valid), .i_req_addr(i_req_addr),
  .i_req_burst(i_req_burst), .o_res_valid(o_res_valid), .o_res_addr(o_res_addr),
  .o_res_bytes(o_res_bytes), .o_res_endian(o_res_endian), .o_res_disconnect(o_res_disconnect)
);
`default_nettype wire

// ---- tiw_pci_master.sv ----
// pci master side model issuing one-cycle decode requests
// assumes the bench calls send and the block samples on i_core_clk
`timescale 1ns/1ps
`default_nettype none
module tiw_pci_master (
  input  wire logic        i_core_clk,
  output logic             o_valid,
  output logic [1:0]       o_image,
  output logic [31:0]      o_addr,
  output logic [1:0]       o_cmd,
  output logic [2:0]       o_master,
  output logic             o_burst
);
  initial begin
    o_valid = 1'b0;
    o_image = 2'h0;
    o_addr = 32'h0;
    o_cmd = 2'h0;
    o_master = 3'h0;
    o_burst = 1'b0;
  end
  // one strobe; the address turns to junk once the request is gone
  task automatic send(input logic [1:0] img, input logic [31:0] a, input logic [1:0] c,
                      input logic [2:0] m, input logic b);
    @(posedge i_core_clk);
    o_valid <= 1'b1;
    o_image <= img;
    o_addr <= a;
    o_cmd <= c;
    o_master <= m;
    o_burst <= b;
    @(posedge i_core_clk);
    o_valid <= 1'b0;
    o_addr <= ~a;
    o_burst <= ~b;
  endtask
endmodule
`default_nettype wire

// ---- tiw_top_tb.sv ----
// self-checking bench of the target image window decode
// assumes apb register access and the pci master model as request source
`timescale 1ns/1ps
`default_nettype none
module tiw_top_tb;
  import tiw_pkg::*;
  logic        i_core_clk = 1'b0;
  logic        i_sys_rst = 1'b1;
  logic        psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rq_addr, rs_addr;
  logic        rq_v, rq_b, rs_v, rs_claim, rs_disc, rs_keep;
  logic [1:0]  rq_img, rq_cmd, rs_cmd, rs_end;
  logic [2:0]  rq_m;
  logic [7:0]  rs_bytes;
  int          mismatches = 0;
  int          compares = 0;
  always #2.5 i_core_clk = ~i_core_clk;
  tiw_pci_master i_tiw_pci_master (.i_core_clk(i_core_clk), .o_valid(rq_v), .o_image(rq_img),
    .o_addr(rq_addr), .o_cmd(rq_cmd), .o_master(rq_m), .o_burst(rq_b));
  tiw_top i_tiw_top (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .i_req_valid(rq_v), .i_req_image(rq_img),
    .i_req_addr(rq_addr), .i_req_cmd(rq_cmd), .i_req_master(rq_m), .i_req_burst(rq_b),
    .o_res_valid(rs_v), .o_res_claim(rs_claim), .o_res_addr(rs_addr), .o_res_cmd(rs_cmd),
    .o_res_bytes(rs_bytes), .o_res_endian(rs_end), .o_res_disconnect(rs_disc),
    .o_res_keep(rs_keep));
  // ==========================================================================
  // shared tasks
  task automatic close_out();
    if (mismatches == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    @(posedge i_core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge i_core_clk);
    penable <= 1'b1;
    do @(posedge i_core_clk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic req(input logic [1:0] img, input logic [31:0] a, input logic [1:0] c,
                     input logic [2:0] m, input logic b);
    i_tiw_pci_master.send(img, a, c, m, b);
    @(posedge i_core_clk);
    check("res_valid", rs_v, 1'b1);
  endtask
  task automatic mcase(input logic [31:0] ctl, input logic [1:0] c, input logic b,
                       input logic [1:0] ec, input logic [7:0] eb, input logic ed,
                       input logic [1:0] ee);
    wr(CTL_OFS3, ctl);
    req(2'h3, 32'h0001_0000, c, 3'h0, b);
    check("mode_cmd", rs_cmd, ec);
    check("mode_bytes", rs_bytes, eb);
    check("mode_disc", rs_disc, ed);
    check("mode_endian", rs_end, ee);
  endtask
  // ==========================================================================
  // scenarios
  task automatic t_reset();
    logic [31:0] r;
    logic e;
    check("endian_rst", rs_end, ENDIAN_BIG);
    apb(1'b0, CTL_OFS0, 32'h0, r, e);
    check("ctl_rst", r, CTL_RESET);
    wr(TRANSLATION_ADDRESS_OFS1, 32'hFFFF_FFFF);
    apb(1'b0, TRANSLATION_ADDRESS_OFS1, 32'h0, r, e);
    check("translation_address_rw", r, TRANSLATION_ADDRESS_MASK);
    apb(1'b0, 12'h0F0, 32'h0, r, e);
    check("unmapped_err", e, 1'b1);
  endtask
  task automatic t_prefetch();
    for (int k = 0; k < 8; k++) begin
      wr(CTL_OFS1, 32'h4 | (k << AMT_LSB) | (k & 3));
      req(2'h1, 32'h0000_1000, CMD_MEM_READ, 3'h0, 1'b0);
      check("alias_bytes", rs_bytes, (k < 5) ? (8 << k) : 8);
      check("alias_cmd", rs_cmd, CMD_MEM_RDMULT);
      check("pb_endian", rs_end, k & 3);
      wr(CTL_OFS1, k << AMT_LSB);
      req(2'h1, 32'h0000_1000, CMD_MEM_READ, 3'h0, 1'b0);
      check("plain_bytes", rs_bytes, 8'h08);
    end
  endtask
  task automatic t_translate();
    logic [31:0] m;
    logic [31:0] t;
    for (int k = 0; k < 16; k++) begin
      m = 32'hFFFF_FFFF << (16 + k);
      t = 32'hA5C3_0000 ^ (k << 20);
      wr(CTL_OFS2, 32'h2002 | (k << BS_LSB));
      wr(TRANSLATION_ADDRESS_OFS2, t);
      req(2'h2, 32'h5A3C_9876, CMD_MEM_RDMULT, 3'h0, 1'b0);
      check("xlat_addr", rs_addr, (t & m) | (32'h5A3C_9876 & ~m));
    end
    wr(CTL_OFS2, 32'h0002);
    req(2'h2, 32'h5A3C_9876, CMD_MEM_RDMULT, 3'h0, 1'b0);
    check("no_xlat", rs_addr, 32'h5A3C_9876);
  endtask
  task automatic t_mode();
    mcase(32'h9400, CMD_IO, 1'b1, CMD_IO, 8'h04, 1'b1, 2'h2);
    check("io_keep", rs_keep, 1'b0);
    mcase(32'h9C00, CMD_IO, 1'b0, CMD_MEM_READ, 8'h04, 1'b0, 2'h2);
    mcase(32'h9000, CMD_MEM_READ, 1'b1, CMD_MEM_READ, 8'h08, 1'b0, 2'h2);
    check("mem_keep", rs_keep, 1'b1);
    mcase(32'h0400, CMD_MEM_READ, 1'b1, CMD_MEM_READ, 8'h08, 1'b0, 2'h0);
    mcase(32'h0801, CMD_IO, 1'b0, CMD_MEM_READ, 8'h04, 1'b0, 2'h1);
  endtask
  task automatic t_master();
    wr(GLOBAL_OFS, 32'hF);
    wr(CTL_OFS0, 32'h4002);
    wr(TRANSLATION_ADDRESS_OFS0, 32'h0000_0054);
    for (int m = 0; m < 8; m++) begin
      req(2'h0, 32'h0000_2000, CMD_MEM_READ, 3'(m), 1'b0);
      check("msel_claim", rs_claim, m != 0 && m % 2 == 0);
    end
    wr(GLOBAL_OFS, 32'h1);
    req(2'h0, 32'h0000_2000, CMD_MEM_READ, 3'h6, 1'b0);
    check("pin_off_claim", rs_claim, 1'b0);
    req(2'h0, 32'h0000_2000, CMD_MEM_READ, 3'h4, 1'b0);
    check("pin_prim_claim", rs_claim, 1'b1);
    wr(GLOBAL_OFS, 32'h0);
    req(2'h0, 32'h0000_2000, CMD_MEM_READ, 3'h1, 1'b0);
    check("arb_off_claim", rs_claim, 1'b1);
    wr(GLOBAL_OFS, 32'h1);
    wr(CTL_OFS0, 32'h0002);
    req(2'h0, 32'h0000_2000, CMD_MEM_READ, 3'h1, 1'b0);
    check("md_off_claim", rs_claim, 1'b1);
  endtask
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    repeat (10) @(posedge i_core_clk);
    i_sys_rst <= 1'b0;
    t_reset();
    t_prefetch();
    t_translate();
    t_mode();
    t_master();
    close_out();
  end
  initial begin
    repeat (20000) @(posedge i_core_clk);
    mismatches++;
    close_out();
  end
endmodule
`default_nettype wire
